// ---- logic/fps_outputs.sv ----
// Purpose: Pulse/frequency output, status output and temperature processing.
// Assumes: sample_tick marks one flow sample every SAMPLE_CYC clocks.
// Notes:   Counted quantity per sample is flow magnitude in sensor units, scaled by prog_factor for programmable units.
`timescale 1ns/1ps
module fps_outputs
  import fps_pkg::*;
#(
  parameter int unsigned HALF_MIN = HALF_MIN_CYC,
  parameter int unsigned CYC_MS   = CYC_PER_MS,
  parameter int unsigned SAMPLE   = SAMPLE_CYC
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire fps_cfg_type      cfg,
  input  wire fps_meas_type     meas,
  input  wire logic             sample_tick,
  input  wire logic             prog_mode,
  input  wire logic             temp_cfg_wr,
  input  wire fps_temp_cfg_type temp_cfg_in,
  output logic                  pulse_out,
  output logic                  status_closed,
  output logic                  pulse_param_err,
  output logic                  pulse_saturated,
  output logic                  temp_alarm_low,
  output logic                  temp_alarm_high,
  output logic [15:0]           temp_current_code,
  output logic signed [TEMP_W-1:0] temp_peak,
  output fps_temp_cfg_type      temp_cfg
);

  // ----------------------------------------------------------------
  // Flow selection
  // ----------------------------------------------------------------
  logic              is_mass;
  logic [FLOW_W-1:0] mag;
  logic [FLOW_W-1:0] mag_c;
  logic [FLOW_W-1:0] qty;
  logic [FLOW_W-1:0] urv_q;
  logic              cut;
  logic [39:0]       pscale;
  logic [39:0]       uscale;

  // Mass-type units follow mass flow, volume-type units follow volume flow.
  assign is_mass = (cfg.unit == U_MASS) || (cfg.unit == U_PMASS);
  assign mag = is_mass ?
    (meas.mass_flow_rate[FLOW_W-1] ? FLOW_W'(-meas.mass_flow_rate) : meas.mass_flow_rate) :
    (meas.volume_flow_rate[FLOW_W-1] ? FLOW_W'(-meas.volume_flow_rate) : meas.volume_flow_rate);
  assign mag_c = (mag > cfg.urv_flow) ? cfg.urv_flow : mag;
  assign cut = mag < cfg.low_cut;
  assign pscale = (40'(mag) * 40'(cfg.prog_factor)) >> FACTOR_FRAC;
  assign uscale = (40'(cfg.urv_flow) * 40'(cfg.prog_factor)) >> FACTOR_FRAC;
  assign qty = cfg.unit[1] ? FLOW_W'(pscale) : mag;
  assign urv_q = cfg.unit[1] ? FLOW_W'(uscale) : cfg.urv_flow;

  // ----------------------------------------------------------------
  // Frequency mode
  // ----------------------------------------------------------------
  logic [51:0] facc;
  logic [52:0] next_facc;
  logic [51:0] fthr;
  logic        freq_sq;

  // A toggle every HALF_MIN clocks at upper-range flow gives the maximum rate exactly, with no divider.
  assign fthr = 52'(cfg.urv_flow) * 52'(HALF_MIN);
  assign next_facc = 53'(facc) + 53'(mag_c);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      facc <= '0;
      freq_sq <= 1'b0;
    end else if (!cfg.freq_mode || cut || cfg.urv_flow == '0) begin
      facc <= '0;
      freq_sq <= 1'b0;
    end else if (next_facc >= 53'(fthr)) begin
      facc <= 52'(next_facc - 53'(fthr));
      freq_sq <= ~freq_sq;
    end else begin
      facc <= 52'(next_facc);
    end
  end

  // ----------------------------------------------------------------
  // Pulse mode accumulation
  // ----------------------------------------------------------------
  logic [47:0] pacc;
  logic [47:0] add_q;
  logic        take;
  logic        consume;
  logic [15:0] backlog;

  assign add_q = 48'(qty) * 48'(cfg.pulse_value);
  assign take = !cfg.freq_mode && cfg.unit_quanta != '0 && pacc >= 48'(cfg.unit_quanta);

  // One unit is drained per clock; samples are far sparser than that.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pacc <= '0;
    end else if (cfg.freq_mode) begin
      pacc <= '0;
    end else begin
      pacc <= pacc + (sample_tick ? add_q : '0) - (take ? 48'(cfg.unit_quanta) : '0);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      backlog <= '0;
    end else if (cfg.freq_mode) begin
      backlog <= '0;
    end else if (take && !consume && backlog != BACKLOG_MAX) begin
      backlog <= backlog + 16'h0001;
    end else if (consume && !take) begin
      backlog <= backlog - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Pulse timing
  // ----------------------------------------------------------------
  fps_state_type state;
  logic [31:0]   cnt;
  logic [31:0]   w_set;
  logic [31:0]   w_eff;
  logic [79:0]   need;
  logic [79:0]   have;
  logic          pulse2;

  assign w_set = (32'(cfg.pulse_width_ms) * CYC_MS > HALF_MIN) ?
                 32'(cfg.pulse_width_ms) * CYC_MS : HALF_MIN;
  assign w_eff = (backlog > 16'h0001) ? HALF_MIN : w_set;
  assign consume = (backlog != '0) &&
                   ((state == S_IDLE) || (state == S_LOW && cnt == w_eff - 1));

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= S_IDLE;
      cnt <= '0;
    end else begin
      case (state)
        S_IDLE: begin
          cnt <= '0;
          if (consume) state <= S_HIGH;
        end
        S_HIGH: begin
          if (cnt >= w_eff - 1) begin
            state <= S_LOW;
            cnt <= '0;
          end else cnt <= cnt + 32'h1;
        end
        S_LOW: begin
          if (cnt >= w_eff - 1) begin
            state <= consume ? S_HIGH : S_IDLE;
            cnt <= '0;
          end else cnt <= cnt + 32'h1;
        end
        default: begin
          state <= S_IDLE;
          cnt <= '0;
        end
      endcase
    end
  end

  assign pulse2 = (state == S_HIGH && cnt >= (w_eff >> 1)) ||
                  (state == S_LOW && cnt < (w_eff >> 1));

  assign need = 80'(urv_q) * 80'(cfg.pulse_value) * 80'(2) * 80'(w_set);
  assign have = 80'(cfg.unit_quanta) * 80'(SAMPLE);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pulse_param_err <= 1'b0;
      pulse_saturated <= 1'b0;
      pulse_out <= 1'b0;
    end else begin
      pulse_param_err <= !cfg.freq_mode && (need > have);
      pulse_saturated <= !cfg.freq_mode && (backlog > 16'h0001);
      pulse_out <= cfg.freq_mode ? freq_sq : (state == S_HIGH);
    end
  end

  // ----------------------------------------------------------------
  // Temperature settings and limits
  // ----------------------------------------------------------------
  logic [NLIM-1:0]           viol;
  logic signed [LIM_W-1:0]   lv [NLIM];
  logic signed [LIM_W-1:0]   ll [NLIM];
  logic signed [LIM_W-1:0]   lh [NLIM];

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      temp_cfg <= '{2'h0, TEMP_LRV_RST, TEMP_URV_RST, TEMP_MIN_RST, TEMP_MAX_RST};
    end else if (prog_mode && temp_cfg_wr) begin
      temp_cfg <= temp_cfg_in;
    end
  end

  // all values share the stored unit, so no conversion is applied here.
  always_comb begin
    lv[L_QM_MIN] = LIM_W'(meas.mass_flow_rate);
    lv[L_QM_MAX] = LIM_W'(meas.mass_flow_rate);
    lv[L_DN_MIN] = LIM_W'({1'b0, meas.density});
    lv[L_DN_MAX] = LIM_W'({1'b0, meas.density});
    lv[L_T_MIN]  = LIM_W'(meas.temp);
    lv[L_T_MAX]  = LIM_W'(meas.temp);
    ll[L_QM_MIN] = LIM_W'(cfg.qm_min);
    ll[L_QM_MAX] = LIM_W'(cfg.qm_max);
    ll[L_DN_MIN] = LIM_W'({1'b0, cfg.den_min});
    ll[L_DN_MAX] = LIM_W'({1'b0, cfg.den_max});
    ll[L_T_MIN]  = LIM_W'(temp_cfg.tmin);
    ll[L_T_MAX]  = LIM_W'(temp_cfg.tmax);
    for (int i = 0; i < NLIM; i++) lh[i] = '0;
    lh[L_DN_MIN] = LIM_W'({1'b0, cfg.den_hyst});
    lh[L_DN_MAX] = LIM_W'({1'b0, cfg.den_hyst});
  end

  for (genvar g = 0; g < NLIM; g++) begin : g_lim
    fps_limit_cmp #(.WIDTH(LIM_W)) u_cmp (
      .clock    (clock),
      .arst_n   (arst_n),
      .value    (lv[g]),
      .limit    (ll[g]),
      .hyst     (lh[g]),
      .is_max   ((g % 2) == 1),
      .violated (viol[g])
    );
  end

  assign temp_alarm_low  = viol[L_T_MIN];
  assign temp_alarm_high = viol[L_T_MAX];

  // ----------------------------------------------------------------
  // Temperature current code and peak
  // ----------------------------------------------------------------
  logic signed [16:0] tspan;
  logic signed [16:0] toff;
  logic [31:0]        tnum;

  assign tspan = 17'(temp_cfg.urv) - 17'(temp_cfg.lrv);
  assign toff  = 17'(meas.temp) - 17'(temp_cfg.lrv);
  assign tnum  = 32'(toff[15:0]) * 32'(CUR_FULL);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      temp_current_code <= CUR_MIN;
    end else if (toff <= 0 || tspan <= 0) begin
      temp_current_code <= CUR_MIN;
    end else if (toff >= tspan) begin
      temp_current_code <= CUR_FULL;
    end else begin
      temp_current_code <= 16'(tnum / 32'(tspan[15:0]));
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) temp_peak <= TEMP_MIN_RST;
    else if (meas.temp > temp_peak) temp_peak <= meas.temp;
  end

  // ----------------------------------------------------------------
  // Status output
  // ----------------------------------------------------------------
  logic active;
  logic alarm_any;

  assign alarm_any = (|viol) || meas.selftest_err;

  always_comb begin
    case (cfg.asg)
      A_FWD:    active = !meas.mass_flow_rate[FLOW_W-1] && meas.mass_flow_rate != '0;
      A_REV:    active = meas.mass_flow_rate[FLOW_W-1];
      A_QM_MIN: active = viol[L_QM_MIN];
      A_QM_MAX: active = viol[L_QM_MAX];
      A_DN_MIN: active = viol[L_DN_MIN];
      A_DN_MAX: active = viol[L_DN_MAX];
      A_T_MIN:  active = viol[L_T_MIN];
      A_T_MAX:  active = viol[L_T_MAX];
      A_ALARM:  active = alarm_any;
      A_PULSE2: active = !cfg.freq_mode && pulse2;
      default:  active = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) status_closed <= 1'b0;
    else status_closed <= active ^ cfg.active_open;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  a_freq_cap: assert property (cfg.freq_mode && !cut && cfg.urv_flow != '0 && $changed(freq_sq) |=> $stable(freq_sq))
    else $error("frequency above maximum");
  a_freq_cut: assert property (cfg.freq_mode && cut |=> ##1 !pulse_out) else $error("output during cutoff");
  a_unit_count: assert property (take && !consume && backlog != BACKLOG_MAX |=> backlog == $past(backlog) + 16'h0001)
    else $error("unit not queued");
  a_width_floor: assert property (state == S_HIGH |-> w_eff >= HALF_MIN && (cnt < w_eff || $changed(w_eff)))
    else $error("pulse too fast");
  a_sat_warn: assert property (!cfg.freq_mode && backlog > 16'h0001 |=> pulse_saturated)
    else $error("saturation not flagged");
  a_param_err: assert property (!cfg.freq_mode && need > have |=> pulse_param_err)
    else $error("parameter error missed");
  a_quad_lag: assert property (cfg.asg == A_PULSE2 && !cfg.freq_mode && $rose(pulse_out)
    |-> status_closed == cfg.active_open) else $error("second train early");
  a_alarm_out: assert property (cfg.asg == A_ALARM && meas.selftest_err |=> status_closed != $past(cfg.active_open))
    else $error("alarm not shown");
  a_peak_keep: assert property (temp_peak >= $past(temp_peak)) else $error("peak dropped");
  a_temp_lock: assert property (!(prog_mode && temp_cfg_wr) |=> $stable(temp_cfg))
    else $error("settings changed");
  a_cur_floor: assert property (toff <= 0 |=> temp_current_code == CUR_MIN) else $error("code not minimum");

  c_freq_toggle: cover property (cfg.freq_mode && $rose(pulse_out));
  c_pulse_emit: cover property (!cfg.freq_mode && state == S_HIGH);
  c_saturated: cover property ($rose(pulse_saturated));
  c_temp_alarm: cover property ($rose(temp_alarm_high));

endmodule : fps_outputs

// ---- logic/fps_pkg.sv ----
// Purpose: Shared constants and types for the flow pulse and status output block.
// Assumes: One 100 MHz clock; measurements arrive from logic on the same clock.
// Notes:   Measured flows are signed, in sensor units, and counted as magnitudes; temperature in the selected unit.
//
// Behaviour
// - Frequency mode reaches 1 kHz exactly at the upper-range flow.
// - Frequency mode outputs zero below the low-flow cutoff.
// - Pulse mode derives pulses per quantity from pulse value and counted unit.
// - Flag a parameter error when pulses cannot keep up at upper-range flow.
// - Shorten an overlong pulse width automatically and raise a saturation warning.
// - Pulse rate at most one over twice the width, never above 1000 Hz.
// - Count in mass, volume, or programmable units scaled by a stored factor.
// - Emit the configured number of pulses for each counted unit.
// - Status output polarity selectable as closed or open when active.
// - Status output assignable to direction, limits, alarm or second pulse train.
// - Alarm assignment goes active on any limit violation or self-test error.
// - Second pulse train on status output lags main pulses by ninety degrees.
// - Temperature below its minimum limit raises an alarm usable as status.
// - Temperature is compared against a separate maximum limit usable as status.
// - Temperature below lower-range value drives the current code to its minimum.
// - Current code scales linearly, full scale at the upper-range temperature.
// - Peak temperature is held and can never be cleared.
// - Temperature settings change only in programming mode.
// - Selected temperature unit applies to all temperature values and limits.
package fps_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned FMAX_HZ      = 1000;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned CYC_PER_MS   = CLK_HZ / MS_PER_S;
  localparam int unsigned HALF_MIN_CYC = CLK_HZ / (2 * FMAX_HZ);
  localparam int unsigned SAMPLE_CYC   = CYC_PER_MS;

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int FLOW_W = 24;
  localparam int TEMP_W = 16;
  localparam int LIM_W  = 25;
  localparam int NLIM   = 6;
  localparam logic [15:0] CUR_FULL     = 16'hffff;
  localparam logic [15:0] CUR_MIN      = 16'h0000;
  localparam logic [15:0] BACKLOG_MAX  = 16'hffff;
  localparam logic [15:0] TEMP_LRV_RST = 16'h0005;
  localparam logic [15:0] TEMP_URV_RST = 16'h005a;
  localparam logic [15:0] TEMP_MIN_RST = 16'h8000;
  localparam logic [15:0] TEMP_MAX_RST = 16'h7fff;
  localparam int FACTOR_FRAC = 16;

  // Limit slots in the comparator array.
  localparam int L_QM_MIN = 0;
  localparam int L_QM_MAX = 1;
  localparam int L_DN_MIN = 2;
  localparam int L_DN_MAX = 3;
  localparam int L_T_MIN  = 4;
  localparam int L_T_MAX  = 5;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    U_MASS = 2'h0, U_VOL = 2'h1, U_PMASS = 2'h2, U_PVOL = 2'h3
  } fps_unit_type;

  typedef enum logic [9:0] {
    A_FWD    = 10'h001, A_REV   = 10'h002, A_QM_MIN = 10'h004,
    A_QM_MAX = 10'h008, A_DN_MIN = 10'h010, A_DN_MAX = 10'h020,
    A_T_MIN  = 10'h040, A_T_MAX = 10'h080, A_ALARM  = 10'h100,
    A_PULSE2 = 10'h200
  } fps_asg_type;

  typedef enum logic [2:0] {
    S_IDLE = 3'h1, S_HIGH = 3'h2, S_LOW = 3'h4
  } fps_state_type;

  typedef struct packed {
    logic                       freq_mode;
    fps_unit_type               unit;
    logic [15:0]                pulse_value;
    logic [31:0]                unit_quanta;
    logic [15:0]                prog_factor;
    logic [15:0]                pulse_width_ms;
    logic [FLOW_W-1:0]          urv_flow;
    logic [FLOW_W-1:0]          low_cut;
    logic signed [FLOW_W-1:0]   qm_min;
    logic signed [FLOW_W-1:0]   qm_max;
    logic [15:0]                den_min;
    logic [15:0]                den_max;
    logic [15:0]                den_hyst;
    logic                       active_open;
    fps_asg_type                asg;
  } fps_cfg_type;

  typedef struct packed {
    logic signed [FLOW_W-1:0]   mass_flow_rate;
    logic signed [FLOW_W-1:0]   volume_flow_rate;
    logic [15:0]                density;
    logic signed [TEMP_W-1:0]   temp;
    logic                       selftest_err;
  } fps_meas_type;

  typedef struct packed {
    logic [1:0]                 unit;
    logic signed [TEMP_W-1:0]   lrv;
    logic signed [TEMP_W-1:0]   urv;
    logic signed [TEMP_W-1:0]   tmin;
    logic signed [TEMP_W-1:0]   tmax;
  } fps_temp_cfg_type;

endpackage : fps_pkg

// ---- logic/fps_limit_cmp.sv ----
// Purpose: One limit comparator with hysteresis and a registered verdict.
// Assumes: Value, limit and hysteresis share one unit and one clock.
// Notes:   A max limit trips above the limit and clears below limit minus hysteresis.
`timescale 1ns/1ps
module fps_limit_cmp
  import fps_pkg::*;
#(
  parameter int WIDTH = LIM_W
) (
  input  wire logic                    clock,
  input  wire logic                    arst_n,
  input  wire logic signed [WIDTH-1:0] value,
  input  wire logic signed [WIDTH-1:0] limit,
  input  wire logic signed [WIDTH-1:0] hyst,
  input  wire logic                    is_max,
  output logic                         violated
);

  logic signed [WIDTH:0] lo;
  logic signed [WIDTH:0] hi;

  // Release point lies hysteresis away from the trip point, on the safe side.
  assign lo = (WIDTH+1)'(limit) - (WIDTH+1)'(hyst);
  assign hi = (WIDTH+1)'(limit) + (WIDTH+1)'(hyst);

  // Verdict holds between trip and release to stop chatter near the limit.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      violated <= 1'b0;
    end else if (is_max) begin
      if (value > limit) violated <= 1'b1;
      else if (value < lo) violated <= 1'b0;
    end else begin
      if (value < limit) violated <= 1'b1;
      else if (value > hi) violated <= 1'b0;
    end
  end

endmodule : fps_limit_cmp

// ---- dv/fps_pulse_counter.sv ----
// Purpose: Counter model that watches the pulse line and the status line.
// Assumes: Both lines are sampled on the block clock.
// Notes:   All lengths are in clock cycles; nothing is debounced.
`timescale 1ns/1ps
module fps_pulse_counter (
  input  wire logic clock,
  input  wire logic clear,
  input  wire logic pulse,
  input  wire logic quad,
  output int        edges,
  output int        high_len,
  output int        period,
  output int        min_high,
  output int        lag
);
  int   run;
  int   since_rise;
  logic pulse_q = 1'b0;
  logic quad_q  = 1'b0;

  // ----------------------------------------------------------------
  // Edge counting and width capture
  // ----------------------------------------------------------------
  // A real counter only sees edges, so the model reports edges and lengths only.
  always @(posedge clock) begin
    pulse_q    <= pulse;
    quad_q     <= quad;
    since_rise <= since_rise + 1;
    run        <= pulse ? run + 1 : 0;
    if (pulse && !pulse_q) begin
      edges      <= edges + 1;
      period     <= since_rise;
      since_rise <= 1;
    end
    if (!pulse && pulse_q) begin
      high_len <= run;
      if (run < min_high) begin
        min_high <= run;
      end
    end
    if (quad && !quad_q) begin
      lag <= since_rise;
    end
    if (clear) begin
      edges    <= 0;
      min_high <= 1000000;
    end
  end
endmodule : fps_pulse_counter

// ---- dv/fps_outputs_test.sv ----
// Purpose: Self-checking bench for the pulse, status and temperature outputs.
// Assumes: Shortened timing, 10 cycles minimum half period, 20 cycles per ms.
// Notes:   Expected figures are worked out from those two parameters.
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; $display("BAD %0t mismatch line %0d", $time, `__LINE__); end end
module fps_outputs_test;
  import fps_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic sample_tick = 1'b0;
  logic prog_mode = 1'b0;
  logic temp_cfg_wr = 1'b0;
  logic clear = 1'b0;
  fps_cfg_type cfg;
  fps_meas_type meas;
  fps_temp_cfg_type tc;
  fps_temp_cfg_type temp_cfg;
  logic pulse_out, status_closed, pulse_param_err, pulse_saturated, temp_alarm_low, temp_alarm_high;
  logic [15:0] temp_current_code;
  logic signed [15:0] temp_peak;
  int edges, high_len, period, min_high, lag;
  int failures = 0;
  int comparisons = 0;
  fps_asg_type sa[11] = '{A_FWD, A_FWD, A_REV, A_QM_MIN, A_QM_MAX, A_DN_MIN, A_DN_MAX, A_T_MIN, A_T_MAX, A_ALARM, A_ALARM};
  int sm[11] = '{5, -5, -5, -200, 200, 5, 5, 5, 5, 5, 5};
  int sd[11] = '{256, 256, 256, 256, 256, 8, 8192, 256, 256, 256, 256};
  int st[11] = '{30, 30, 30, 30, 30, 30, 30, -5, 120, 30, 30};
  int tt[4] = '{-5, 50, 100, 120};
  logic [15:0] tcode[4] = '{16'h0000, 16'h7fff, 16'hffff, 16'hffff};
  int um[4] = '{10, 0, 20, 0};
  int uv[4] = '{0, 10, 0, 20};
  int ff[4] = '{10, 5, 20, 1};
  int fp[4] = '{20, 40, 20, 0};

  // Clock at 100 MHz.
  always #5 clock = ~clock;

  fps_outputs #(.HALF_MIN(10), .CYC_MS(20), .SAMPLE(20)) i_dut (
    .clock(clock), .arst_n(arst_n), .cfg(cfg), .meas(meas), .sample_tick(sample_tick),
    .prog_mode(prog_mode), .temp_cfg_wr(temp_cfg_wr), .temp_cfg_in(tc), .pulse_out(pulse_out),
    .status_closed(status_closed), .pulse_param_err(pulse_param_err), .pulse_saturated(pulse_saturated),
    .temp_alarm_low(temp_alarm_low), .temp_alarm_high(temp_alarm_high),
    .temp_current_code(temp_current_code), .temp_peak(temp_peak), .temp_cfg(temp_cfg));

  fps_pulse_counter i_counter (
    .clock(clock), .clear(clear), .pulse(pulse_out), .quad(status_closed), .edges(edges),
    .high_len(high_len), .period(period), .min_high(min_high), .lag(lag));

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  // One flow sample every 20 cycles, matching the shortened sample period.
  task ticks(input int n);
    repeat (n) begin
      sample_tick = 1'b1;
      cyc(1);
      sample_tick = 1'b0;
      cyc(19);
    end
  endtask : ticks

  task wr_temp(input logic pm);
    prog_mode = pm;
    temp_cfg_wr = 1'b1;
    cyc(1);
    temp_cfg_wr = 1'b0;
    prog_mode = 1'b0;
    cyc(2);
  endtask : wr_temp

  task restart;
    clear = 1'b1;
    cyc(1);
    clear = 1'b0;
  endtask : restart

  task end_of_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  // The tests need about 5600 cycles; 50000 leaves ample margin.
  initial begin
    repeat (50000) @(posedge clock);
    failures++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    cfg = '0;
    cfg.unit = U_MASS;
    cfg.pulse_value = 16'h0002;
    cfg.unit_quanta = 32'h0000_0064;
    cfg.prog_factor = 16'h8000;
    cfg.pulse_width_ms = 16'h0001;
    cfg.urv_flow = 24'h00000a;
    cfg.low_cut = 24'h000002;
    cfg.qm_min = 24'hffff9c;
    cfg.qm_max = 24'h000064;
    cfg.den_min = 16'h0010;
    cfg.den_max = 16'h1000;
    cfg.asg = A_FWD;
    meas = '0;
    meas.density = 16'h0100;
    tc = {2'h1, 16'h0000, 16'h0064, 16'h000a, 16'h0032};
    cyc(3);
    `CHK(temp_peak, 16'h8000)
    `CHK(status_closed, 1'b0)
    arst_n = 1'b1;
    cyc(1);
    `CHK(temp_peak, 16'h0000)
    wr_temp(1'b0);
    `CHK(temp_cfg, {2'h0, 16'h0005, 16'h005a, 16'h8000, 16'h7fff})
    wr_temp(1'b1);
    `CHK(temp_cfg, tc)
    for (int i = 0; i < 4; i++) begin
      meas.temp = 16'(tt[i]);
      cyc(4);
      `CHK(temp_current_code, tcode[i])
      `CHK(temp_alarm_low, 1'(i == 0))
      `CHK(temp_alarm_high, 1'(i > 1))
    end
    meas.temp = 16'h001e;
    cyc(4);
    `CHK(temp_peak, 16'h0078)
    for (int ao = 0; ao < 2; ao++) begin
      for (int i = 0; i < 11; i++) begin
        cfg.active_open = 1'(ao);
        cfg.asg = sa[i];
        meas.mass_flow_rate = 24'(sm[i]);
        meas.density = 16'(sd[i]);
        meas.temp = 16'(st[i]);
        meas.selftest_err = (i == 9);
        cyc(4);
        `CHK(status_closed, 1'((i != 1 && i != 10) ^ ao))
      end
    end
    cfg.active_open = 1'b0;
    meas.selftest_err = 1'b0;
    meas.temp = 16'h001e;
    meas.density = 16'h0100;
    cfg.asg = A_PULSE2;
    // each counted unit, two pulses per unit of 100
    for (int u = 0; u < 4; u++) begin
      cfg.unit = fps_unit_type'(u);
      meas.mass_flow_rate = 24'(um[u]);
      meas.volume_flow_rate = 24'(uv[u]);
      restart();
      ticks(20);
      cyc(100);
      `CHK(edges, 4)
      `CHK(high_len, 20)
      `CHK((lag >= 9 && lag <= 11), 1'b1)
      `CHK(pulse_param_err, 1'b0)
      `CHK(pulse_saturated, 1'b0)
    end
    // an overlong width with two units per sample, so pulses pile up
    cfg.unit = U_MASS;
    meas.mass_flow_rate = 24'h00000a;
    cfg.pulse_width_ms = 16'h000a;
    cfg.unit_quanta = 32'h0000_000a;
    restart();
    ticks(20);
    `CHK(pulse_param_err, 1'b1)
    `CHK(pulse_saturated, 1'b1)
    cyc(2000);
    `CHK(min_high, 10)
    `CHK(edges, 40)
    `CHK(pulse_saturated, 1'b0)
    // frequency mode at, below and above full scale, then under cutoff
    cfg.pulse_width_ms = 16'h0001;
    cfg.freq_mode = 1'b1;
    for (int i = 0; i < 4; i++) begin
      meas.mass_flow_rate = 24'(ff[i]);
      cyc(60);
      restart();
      cyc(200);
      if (fp[i] == 0) begin
        `CHK(edges, 0)
      end else begin
        `CHK(period, fp[i])
      end
    end
    end_of_test();
  end
endmodule : fps_outputs_test
